// File: design/optical_mgmt_pkg.sv
// Constants and types for the optical module management block
package optical_mgmt_pkg;

   // Two-wire device selects, 7-bit form of the 8-bit addresses
   localparam logic [6:0] ID_DEV_ADDR   = 7'h50;   // 0xA0 byte form
   localparam logic [6:0] DIAG_DEV_ADDR = 7'h51;   // 0xA2 byte form

   // Diagnostic map offsets (live monitors, big-endian pairs)
   localparam logic [7:0] MON_TEMP_HI  = 8'h60;
   localparam logic [7:0] MON_TEMP_LO  = 8'h61;
   localparam logic [7:0] MON_VCC_HI   = 8'h62;
   localparam logic [7:0] MON_VCC_LO   = 8'h63;
   localparam logic [7:0] MON_BIAS_HI  = 8'h64;
   localparam logic [7:0] MON_BIAS_LO  = 8'h65;
   localparam logic [7:0] MON_TXPWR_HI = 8'h66;
   localparam logic [7:0] MON_TXPWR_LO = 8'h67;
   localparam logic [7:0] MON_RXPWR_HI = 8'h68;
   localparam logic [7:0] MON_RXPWR_LO = 8'h69;

   // transmit_control_and_status register and its fields
   localparam logic [7:0] TRANSMIT_CONTROL_AND_STATUS = 8'h6e;
   localparam int         TCS_PIN_STATE_BIT   = 7;
   localparam int         TCS_SOFT_DISABLE_BIT = 6;
   localparam int         TCS_FAULT_BIT       = 2;
   localparam int         TCS_LIGHT_LOST_BIT  = 1;
   localparam logic       SOFT_DISABLE_RESET  = 1'b0;

   localparam int         MEM_WORDS = 512;

   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] vcc;
      logic [15:0] bias;
      logic [15:0] tx_power;
      logic [15:0] rx_power;
   } monitor_t;

   typedef enum logic [6:0] {
      ST_IDLE     = 7'b000_0001,
      ST_ADDR     = 7'b000_0010,
      ST_ADDR_ACK = 7'b000_0100,
      ST_WR       = 7'b000_1000,
      ST_WR_ACK   = 7'b001_0000,
      ST_RD       = 7'b010_0000,
      ST_RD_ACK   = 7'b100_0000
   } link_state_t;

endpackage

// File: design/optical_module_mgmt_txdisable.sv
// Two-wire management slave with transmit-disable and fault latch
`timescale 1ns/1ps

// Function
// - Identification map at 0xA0, bytes 0-255
// - Diagnostic map at 0xA2, 256 bytes
// - Diagnostic map reports laser bias and power
// - Diagnostic map reports supply, temperature, received power
// - Disable pin and light loss mirrored
// - Pin high turns transmitter off
// - Cycling pin resets transmitter fault
// - Pin reads high during reset, transmitter off
// - Byte 110 bit6 soft off, bit7 status
// - Soft bit OR pin disables transmitter
// - Fault latches high until pin toggles
// - Latched fault readable at byte 110 bit2
// - Light loss high, readable byte 110 bit1
module optical_module_mgmt_txdisable
   import optical_mgmt_pkg::*;
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire logic     scl,
   input  wire logic     sda_i,
   output logic          sda_o,
   output logic          sda_oe,
   input  wire logic     tx_off_pin,
   input  wire logic     laser_fault_in,
   input  wire logic     input_light_missing,
   input  wire monitor_t monitors,
   output logic          tx_laser_off,
   output logic          tx_fault,
   output logic          receive_signal_lost
);

   logic        scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
   logic        pin_m, pin_s, pin_q, flt_m, flt_s, dark_m, dark_s;
   link_state_t state;
   logic [7:0]  shift, rd_shift, ptr, next_byte;
   logic [2:0]  bit_cnt;
   logic        map_sel, rw, first, ack_drv, soft_off;
   logic [7:0]  mem [MEM_WORDS];
   logic        start_c, stop_c, rise, fall, wr_en, pin_edge;
   logic [7:0]  wr_data;

   // Two-flop synchronisers; the pin chain resets high as the pull-up would
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_m, scl_s, scl_q} <= 3'b111;
         {sda_m, sda_s, sda_q} <= 3'b111;
         {pin_m, pin_s, pin_q} <= 3'b111;
         {flt_m, flt_s}        <= 2'b00;
         {dark_m, dark_s}      <= 2'b00;
      end else begin
         {scl_m, scl_s, scl_q} <= {scl, scl_m, scl_s};
         {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
         {pin_m, pin_s, pin_q} <= {tx_off_pin, pin_m, pin_s};
         {flt_m, flt_s}        <= {laser_fault_in, flt_m};
         {dark_m, dark_s}      <= {input_light_missing, dark_m};
      end
   end

   assign start_c  = scl_s & sda_q & ~sda_s;
   assign stop_c   = scl_s & ~sda_q & sda_s;
   assign rise     = scl_s & ~scl_q;
   assign fall     = ~scl_s & scl_q;
   assign pin_edge = pin_s ^ pin_q;
   assign wr_data  = {shift[6:0], sda_s};
   assign wr_en    = (state == ST_WR) && rise && (bit_cnt == 3'd7) && !first;
   assign sda_o    = 1'b0;

   // Byte presented to the host; live values are captured when the byte loads
   always_comb begin
      next_byte = mem[{map_sel, ptr}];
      if (map_sel) begin
         case (ptr)
            MON_TEMP_HI:  next_byte = monitors.temp[15:8];
            MON_TEMP_LO:  next_byte = monitors.temp[7:0];
            MON_VCC_HI:   next_byte = monitors.vcc[15:8];
            MON_VCC_LO:   next_byte = monitors.vcc[7:0];
            MON_BIAS_HI:  next_byte = monitors.bias[15:8];
            MON_BIAS_LO:  next_byte = monitors.bias[7:0];
            MON_TXPWR_HI: next_byte = monitors.tx_power[15:8];
            MON_TXPWR_LO: next_byte = monitors.tx_power[7:0];
            MON_RXPWR_HI: next_byte = monitors.rx_power[15:8];
            MON_RXPWR_LO: next_byte = monitors.rx_power[7:0];
            TRANSMIT_CONTROL_AND_STATUS: begin
               next_byte = 8'h00;
               next_byte[TCS_PIN_STATE_BIT]    = pin_s;
               next_byte[TCS_SOFT_DISABLE_BIT] = soft_off;
               next_byte[TCS_FAULT_BIT]        = tx_fault;
               next_byte[TCS_LIGHT_LOST_BIT]   = dark_s;
            end
            default: next_byte = mem[{map_sel, ptr}];
         endcase
      end
   end

   // Link state machine; a start or stop overrides any bit in progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state    <= ST_IDLE;
         shift    <= 8'h00;
         rd_shift <= 8'h00;
         bit_cnt  <= 3'd0;
         ptr      <= 8'h00;
         map_sel  <= 1'b0;
         rw       <= 1'b0;
         first    <= 1'b0;
         ack_drv  <= 1'b0;
         sda_oe   <= 1'b0;
      end else if (start_c) begin
         state   <= ST_ADDR;
         bit_cnt <= 3'd0;
         first   <= 1'b1;
         ack_drv <= 1'b0;
         sda_oe  <= 1'b0;
      end else if (stop_c) begin
         state  <= ST_IDLE;
         sda_oe <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: sda_oe <= 1'b0;
            ST_ADDR, ST_WR: if (rise) begin
               shift   <= wr_data;
               bit_cnt <= bit_cnt + 3'd1;
               if (bit_cnt == 3'd7) begin
                  if (state == ST_WR) begin
                     state <= ST_WR_ACK;
                     first <= 1'b0;
                     if (first) ptr <= wr_data;
                     else ptr <= ptr + 8'h01;
                  end else if (shift[6:0] == ID_DEV_ADDR || shift[6:0] == DIAG_DEV_ADDR) begin
                     state   <= ST_ADDR_ACK;
                     map_sel <= shift[0];
                     rw      <= sda_s;
                  end else begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK, ST_WR_ACK: if (fall) begin
               if (!ack_drv) begin
                  ack_drv <= 1'b1;
                  sda_oe  <= 1'b1;
               end else begin
                  ack_drv <= 1'b0;
                  bit_cnt <= 3'd0;
                  if (state == ST_ADDR_ACK && rw) begin
                     state    <= ST_RD;
                     rd_shift <= next_byte;
                     sda_oe   <= ~next_byte[7];
                  end else begin
                     state  <= ST_WR;
                     sda_oe <= 1'b0;
                  end
               end
            end
            ST_RD: if (fall) begin
               if (bit_cnt == 3'd7) begin
                  state  <= ST_RD_ACK;
                  sda_oe <= 1'b0;
                  ptr    <= ptr + 8'h01;
               end else begin
                  rd_shift <= {rd_shift[6:0], 1'b0};
                  sda_oe   <= ~rd_shift[6];
                  bit_cnt  <= bit_cnt + 3'd1;
               end
            end
            ST_RD_ACK: begin
               if (rise && sda_s) state <= ST_IDLE;
               else if (fall) begin
                  state    <= ST_RD;
                  bit_cnt  <= 3'd0;
                  rd_shift <= next_byte;
                  sda_oe   <= ~next_byte[7];
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Host-writable storage; the control byte keeps only its soft bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < MEM_WORDS; i++) mem[i] <= 8'h00;
      end else if (wr_en && !(map_sel && ptr == TRANSMIT_CONTROL_AND_STATUS)) begin
         mem[{map_sel, ptr}] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) soft_off <= SOFT_DISABLE_RESET;
      else if (wr_en && map_sel && ptr == TRANSMIT_CONTROL_AND_STATUS)
         soft_off <= wr_data[TCS_SOFT_DISABLE_BIT];
   end

   // Fault latch: a new fault wins over a pin toggle in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) tx_fault <= 1'b0;
      else if (flt_s) tx_fault <= 1'b1;
      else if (pin_edge) tx_fault <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_laser_off        <= 1'b1;
         receive_signal_lost <= 1'b0;
      end else begin
         tx_laser_off        <= pin_s | soft_off | tx_fault;
         receive_signal_lost <= dark_s;
      end
   end

   sequence addr_byte_done_s;
      state == ST_ADDR && rise && bit_cnt == 3'd7;
   endsequence

   sequence ctrl_write_s;
      wr_en && map_sel && ptr == TRANSMIT_CONTROL_AND_STATUS;
   endsequence

   // Any edge at which a byte is loaded for the host, first byte or follow-on
   sequence byte_load_s;
      fall && !start_c && !stop_c && ((state == ST_ADDR_ACK && ack_drv && rw) || state == ST_RD_ACK);
   endsequence

   id_select_a: assert property (@(posedge clk) disable iff (!rst_n)
      addr_byte_done_s and (shift[6:0] == ID_DEV_ADDR) |=> state == ST_ADDR_ACK && !map_sel)
      else $error("id map select missed");
   diag_select_a: assert property (@(posedge clk) disable iff (!rst_n)
      addr_byte_done_s and (shift[6:0] == DIAG_DEV_ADDR) |=> state == ST_ADDR_ACK && map_sel)
      else $error("diagnostic map select missed");
   bias_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      byte_load_s and (map_sel && ptr == MON_BIAS_HI)
      |=> rd_shift == $past(monitors.bias[15:8]))
      else $error("bias byte not loaded");
   temp_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      byte_load_s and (map_sel && ptr == MON_TEMP_LO)
      |=> rd_shift == $past(monitors.temp[7:0]))
      else $error("temperature byte not loaded");
   soft_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      ctrl_write_s |=> soft_off == $past(wr_data[TCS_SOFT_DISABLE_BIT]))
      else $error("soft disable not stored");
   laser_off_or_a: assert property (@(posedge clk) disable iff (!rst_n)
      ##1 tx_laser_off == ($past(pin_s) | $past(soft_off) | $past(tx_fault)))
      else $error("laser disable not OR of sources");
   fault_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      flt_s |=> tx_fault ##1 tx_laser_off)
      else $error("fault not latched");
   fault_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      tx_fault && !pin_edge |=> tx_fault)
      else $error("fault dropped without pin toggle");
   fault_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      tx_fault && pin_edge && !flt_s |=> !tx_fault)
      else $error("pin toggle did not clear fault");
   pin_status_a: assert property (@(posedge clk) disable iff (!rst_n)
      byte_load_s and (map_sel && ptr == TRANSMIT_CONTROL_AND_STATUS)
      |=> rd_shift[TCS_PIN_STATE_BIT] == $past(pin_s)
      && rd_shift[TCS_LIGHT_LOST_BIT] == $past(dark_s) && rd_shift[TCS_FAULT_BIT] == $past(tx_fault))
      else $error("status byte mismatch");

endmodule // optical_module_mgmt_txdisable

// File: test/optical_module_mgmt_txdisable_bench.sv
// Self-checking bench for the management and transmit-disable block
`timescale 1ns/1ps
module optical_module_mgmt_txdisable_bench;
   import optical_mgmt_pkg::*;
   logic        clk, rst_n, tx_off_pin, laser_fault_in, input_light_missing;
   logic        scl, host_pull, sda_oe, tx_laser_off, tx_fault, receive_signal_lost;
   logic [15:0] v;
   monitor_t    monitors;
   wire logic   sda_w;
   int          failures, cmp_count;
   // Open-drain line with pull-up
   assign sda_w = ~(sda_oe | host_pull);
   optical_module_mgmt_txdisable optical_module_mgmt_txdisable_inst (
      .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
      .tx_off_pin(tx_off_pin), .laser_fault_in(laser_fault_in), .input_light_missing(input_light_missing),
      .monitors(monitors), .tx_laser_off(tx_laser_off), .tx_fault(tx_fault),
      .receive_signal_lost(receive_signal_lost));
   two_wire_host two_wire_host_inst (.scl(scl), .sda_pull(host_pull), .sda(sda_w));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic settle;
      repeat (6) @(negedge clk);
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d);
      logic a, acked;
      acked = 1'b1;
      two_wire_host_inst.start();
      two_wire_host_inst.send({dev, 1'b0}, a);
      acked &= a;
      two_wire_host_inst.send(ptr, a);
      acked &= a;
      two_wire_host_inst.send(d[15:8], a);
      acked &= a;
      two_wire_host_inst.send(d[7:0], a);
      acked &= a;
      two_wire_host_inst.stop();
      chk("write ack", {15'h0000, acked}, 16'h0001);
   endtask
   // Two-byte read through a repeated start; the second byte ends with a NACK
   task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [15:0] d);
      logic a, acked;
      acked = 1'b1;
      two_wire_host_inst.start();
      two_wire_host_inst.send({dev, 1'b0}, a);
      acked &= a;
      two_wire_host_inst.send(ptr, a);
      acked &= a;
      two_wire_host_inst.start();
      two_wire_host_inst.send({dev, 1'b1}, a);
      acked &= a;
      two_wire_host_inst.recv(d[15:8], 1'b0);
      two_wire_host_inst.recv(d[7:0], 1'b1);
      two_wire_host_inst.stop();
      chk("read ack", {15'h0000, acked}, 16'h0001);
   endtask
   task automatic t_pins;
      chk("tx_laser_off", tx_laser_off, 1);
      chk("tx_fault", tx_fault, 0);
      tx_off_pin = 1'b0;
      settle();
      chk("tx_laser_off", tx_laser_off, 0);
      $display("pin test done");
   endtask
   task automatic t_soft;
      wr(DIAG_DEV_ADDR, TRANSMIT_CONTROL_AND_STATUS, 16'h7F00);
      settle();
      chk("tx_laser_off", tx_laser_off, 1);
      rd(DIAG_DEV_ADDR, TRANSMIT_CONTROL_AND_STATUS, v);
      chk("status", {8'h00, v[15:8]}, 16'h0040);
      @(negedge clk);
      tx_off_pin = 1'b1;
      settle();
      rd(DIAG_DEV_ADDR, TRANSMIT_CONTROL_AND_STATUS, v);
      chk("status", {8'h00, v[15:8]}, 16'h00C0);
      wr(DIAG_DEV_ADDR, TRANSMIT_CONTROL_AND_STATUS, 16'h0000);
      @(negedge clk);
      tx_off_pin = 1'b0;
      settle();
      chk("tx_laser_off", tx_laser_off, 0);
      $display("soft disable test done");
   endtask
   task automatic t_fault;
      laser_fault_in = 1'b1;
      repeat (3) @(negedge clk);
      laser_fault_in = 1'b0;
      settle();
      chk("tx_fault", tx_fault, 1);
      chk("tx_laser_off", tx_laser_off, 1);
      rd(DIAG_DEV_ADDR, TRANSMIT_CONTROL_AND_STATUS, v);
      chk("status", {8'h00, v[15:8]}, 16'h0004);
      chk("tx_fault", tx_fault, 1);
      @(negedge clk);
      tx_off_pin = 1'b1;
      settle();
      tx_off_pin = 1'b0;
      settle();
      chk("tx_fault", tx_fault, 0);
      chk("tx_laser_off", tx_laser_off, 0);
      $display("fault test done");
   endtask
   task automatic t_los;
      input_light_missing = 1'b1;
      settle();
      chk("light lost", receive_signal_lost, 1);
      rd(DIAG_DEV_ADDR, TRANSMIT_CONTROL_AND_STATUS, v);
      chk("status", {8'h00, v[15:8]}, 16'h0002);
      @(negedge clk);
      input_light_missing = 1'b0;
      settle();
      chk("light lost", receive_signal_lost, 0);
      $display("light loss test done");
   endtask
   task automatic t_mon;
      for (int i = 0; i < 5; i++) begin
         rd(DIAG_DEV_ADDR, MON_TEMP_HI + 8'(2 * i), v);
         chk("monitor", v, monitors[79 - 16 * i -: 16]);
      end
      $display("monitor test done");
   endtask
   task automatic t_maps;
      logic a;
      wr(ID_DEV_ADDR, 8'hFF, 16'h5AA5);
      rd(ID_DEV_ADDR, 8'hFF, v);
      chk("id wrap", v, 16'h5AA5);
      wr(DIAG_DEV_ADDR, 8'h10, 16'hC33C);
      rd(DIAG_DEV_ADDR, 8'h10, v);
      chk("diag byte", v, 16'hC33C);
      rd(DIAG_DEV_ADDR, 8'hFF, v);
      chk("diag apart", v, 16'h0000);
      two_wire_host_inst.start();
      two_wire_host_inst.send({7'h52, 1'b0}, a);
      two_wire_host_inst.stop();
      chk("foreign ack", {15'h0000, a}, 16'h0000);
      $display("map test done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      tx_off_pin = 1'b1;
      laser_fault_in = 1'b0;
      input_light_missing = 1'b0;
      monitors = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 16'h0F1E};
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      settle();
      t_pins();
      t_soft();
      t_fault();
      t_los();
      t_mon();
      t_maps();
      summarize();
   end
endmodule // optical_module_mgmt_txdisable_bench

// File: test/two_wire_host.sv
// Behavioural two-wire host that drives the management link
`timescale 1ns/1ps
module two_wire_host (
   output logic      scl,
   output logic      sda_pull,
   input  wire logic sda
);
   // Clock parks high between frames; data is only ever pulled low
   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic put_bit(input logic b);
      sda_pull = ~b;
      #31 scl = 1'b1;
      #62 scl = 1'b0;
      #32;
   endtask
   // Sample midway through the high phase so the module's data has long settled
   task automatic get_bit(output logic b);
      sda_pull = 1'b0;
      #31 scl = 1'b1;
      #31 b = sda;
      #31 scl = 1'b0;
      #32;
   endtask
   task automatic start;
      sda_pull = 1'b0;
      #31 scl = 1'b1;
      #62 sda_pull = 1'b1;
      #62 scl = 1'b0;
      #32;
   endtask
   task automatic stop;
      sda_pull = 1'b1;
      #31 scl = 1'b1;
      #62 sda_pull = 1'b0;
      #62;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = ~b;
   endtask
   task automatic recv(output logic [7:0] d, input logic last);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(last);
   endtask
endmodule // two_wire_host
